// [inc/atu_defs.vh]
// Constants for the address translation unit
`ifndef ATU_DEFS_VH
`define ATU_DEFS_VH
`define ATU_VEC_IMISS     20'h01000
`define ATU_VEC_DLMISS    20'h01100
`define ATU_VEC_DSMISS    20'h01200
`define ATU_PAGE_BITS     12
`define ATU_SEG_BITS      28
`define ATU_VSID_W        24
`define ATU_VA_W          52
`define ATU_TLB_ENTRIES   64
`define ATU_TLB_SETS      32
`define ATU_TLB_SET_BITS  5
`define ATU_BAT_ENTRIES   4
`define ATU_BLK_MIN_BITS  17
`define ATU_BLK_MASK_W    11
`define ATU_GRP_BYTES_LOG 6
`define ATU_PP_RW         2'h2
`define ATU_PP_RO         2'h3
`endif

// [test/atu_bench.sv]
// Self-checking bench for the address translation unit
`timescale 1ns/1ps
`include "atu_defs.vh"
module atu_bench;
    logic mclk_in, arst_n_in, instr_translate_enable_in, data_translate_enable_in, supervisor_in;
    logic ifetch_req_in, data_req_in, data_store_in, tlb_ld_in, tlb_ld_data_in, tlb_ld_chg_in;
    logic tlb_inv_in, bat_wr_in, bat_wr_data_in, bat_wr_valid_in, bat_wr_wp_in;
    logic [31:0] ifetch_ea_in, data_ea_in, tlb_inv_ea_in, i_pa_out, d_pa_out, miss_ea_out;
    logic [31:0] grp_addr1_out, grp_addr2_out;
    logic [39:0] tlb_ld_vpn_in;
    logic [19:0] tlb_ld_ppn_in, exc_vector_out;
    logic [14:0] bat_wr_eff_in, bat_wr_phys_in;
    logic [10:0] bat_wr_mask_in;
    logic [1:0]  bat_wr_idx_in;
    logic        i_valid_out, d_valid_out, exc_out, prot_fault_out;
    int          fails = 0;
    int          check_count = 0;
    localparam logic [23:0] VSID = 24'h0a5a5a;

    atu_top atu_top_inst (.mclk_in, .arst_n_in, .ce_in(1'b1), .instr_translate_enable_in,
        .data_translate_enable_in, .supervisor_in, .i_vsid_in(VSID), .d_vsid_in(VSID),
        .table_base_in(16'h0010), .table_mask_in(9'h000), .ifetch_req_in, .ifetch_ea_in,
        .data_req_in, .data_store_in, .data_ea_in, .tlb_ld_in, .tlb_ld_data_in, .tlb_ld_vpn_in,
        .tlb_ld_ppn_in, .tlb_ld_chg_in, .tlb_ld_pp_in(2'h2), .tlb_inv_in, .tlb_inv_ea_in,
        .bat_wr_in, .bat_wr_data_in, .bat_wr_idx_in, .bat_wr_valid_in, .bat_wr_eff_in,
        .bat_wr_phys_in, .bat_wr_mask_in, .bat_wr_wp_in, .i_valid_out, .i_pa_out,
        .d_valid_out, .d_pa_out, .exc_out, .exc_vector_out, .prot_fault_out, .miss_ea_out,
        .grp_addr1_out, .grp_addr2_out);
    atu_core_model atu_core_model_inst (.mclk_in, .ifetch_req_out(ifetch_req_in),
        .ifetch_ea_out(ifetch_ea_in), .data_req_out(data_req_in),
        .data_store_out(data_store_in), .data_ea_out(data_ea_in));

    task chk(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task stop_test();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Translated answer one cycle after the request
    task expect_pa(input logic dat, st, input logic [31:0] ea, pa);
        atu_core_model_inst.issue(dat, st, ea);
        chk({31'h0, dat ? d_valid_out : i_valid_out}, 32'h1);
        chk(dat ? d_pa_out : i_pa_out, pa);
        chk({31'h0, exc_out}, 32'h0);
    endtask
    task expect_miss(input logic dat, st, input logic [31:0] ea, input logic [19:0] vec);
        atu_core_model_inst.issue(dat, st, ea);
        chk({31'h0, exc_out}, 32'h1);
        chk({12'h0, exc_vector_out}, {12'h0, vec});
        chk(miss_ea_out, ea);
    endtask
    // Single-cycle software pulses
    task tlb_load(input logic dat, input logic [31:0] ea, input logic [19:0] ppn, input logic c);
        @(negedge mclk_in);
        {tlb_ld_in, tlb_ld_data_in, tlb_ld_chg_in} = {1'b1, dat, c};
        tlb_ld_vpn_in = {VSID, ea[27:12]};
        tlb_ld_ppn_in = ppn;
        @(negedge mclk_in);
        tlb_ld_in = 1'b0;
    endtask
    task bat_write(input logic dat, input logic [1:0] idx, input logic [14:0] eff, phys,
                   input logic [10:0] mask);
        @(negedge mclk_in);
        {bat_wr_in, bat_wr_data_in, bat_wr_idx_in, bat_wr_valid_in} = {1'b1, dat, idx, 1'b1};
        {bat_wr_eff_in, bat_wr_phys_in, bat_wr_mask_in} = {eff, phys, mask};
        @(negedge mclk_in);
        bat_wr_in = 1'b0;
    endtask

    task t_reset();
        chk({i_valid_out, d_valid_out, exc_out, prot_fault_out}, 32'h0);
        chk(miss_ea_out, 32'h0);
    endtask
    task t_passthru();
        expect_pa(0, 0, 32'h89ab_cdef, 32'h89ab_cdef);
        expect_pa(1, 0, 32'h1357_9bdf, 32'h1357_9bdf);
        expect_pa(1, 1, 32'hfedc_ba98, 32'hfedc_ba98);
    endtask
    task t_misses();
        {instr_translate_enable_in, data_translate_enable_in} = 2'b11;
        expect_miss(0, 0, 32'h0040_1234, `ATU_VEC_IMISS);
        chk(grp_addr1_out, 32'h0010_96c0);
        chk(grp_addr2_out, 32'h0010_6900);
        expect_miss(1, 0, 32'h0050_2344, `ATU_VEC_DLMISS);
        expect_miss(1, 1, 32'h0060_3458, `ATU_VEC_DSMISS);
    endtask
    task t_pages();
        tlb_load(1, 32'h0070_4000, 20'h9a5c3, 1);
        expect_pa(1, 0, 32'h0070_4abc, 32'h9a5c_3abc);
        expect_pa(1, 1, 32'h0070_4ff8, 32'h9a5c_3ff8);
        expect_miss(0, 0, 32'h0070_4abc, `ATU_VEC_IMISS);
        tlb_load(0, 32'h0070_4000, 20'h1f2e3, 1);
        expect_pa(0, 0, 32'h0070_4010, 32'h1f2e_3010);
        tlb_load(1, 32'h0080_5000, 20'h44444, 0);
        expect_miss(1, 1, 32'h0080_5100, `ATU_VEC_DSMISS);
        @(negedge mclk_in);
        {tlb_inv_in, tlb_inv_ea_in} = {1'b1, 32'h0070_4000};
        @(negedge mclk_in);
        tlb_inv_in = 1'b0;
        expect_miss(1, 0, 32'h0070_4abc, `ATU_VEC_DLMISS);
        supervisor_in = 1'b0;
        tlb_load(1, 32'h0090_6000, 20'h55555, 1);
        expect_miss(1, 0, 32'h0090_6000, `ATU_VEC_DLMISS);
        supervisor_in = 1'b1;
    endtask
    task t_blocks();
        bat_write(0, 2'h0, 15'h0001, 15'h2aaa, 11'h000);
        expect_pa(0, 0, 32'h0003_5678, {15'h2aaa, 17'h15678});
        bat_write(1, 2'h3, 15'h5091, 15'h3800, 11'h7ff);
        expect_pa(1, 0, 32'ha123_4568, {4'h7, 28'h123_4568});
        expect_miss(0, 0, 32'ha123_4568, `ATU_VEC_IMISS);
        bat_wr_wp_in = 1'b1;
        bat_write(1, 2'h1, 15'h5091, 15'h6000, 11'h7ff);
        expect_pa(1, 0, 32'ha000_0000, 32'hc000_0000);
        atu_core_model_inst.issue(1, 1, 32'ha000_0000);
        chk({d_valid_out, exc_out, prot_fault_out}, 32'h1);
    endtask

    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end
    // Cut a hang short well past the expected span of about 70 cycles
    initial begin
        #60000;
        fails++;
        stop_test();
    end
    initial begin
        {arst_n_in, instr_translate_enable_in, data_translate_enable_in} = 3'b000;
        {tlb_ld_in, tlb_ld_data_in, tlb_ld_chg_in, tlb_inv_in, bat_wr_in} = 5'h00;
        {bat_wr_wp_in, bat_wr_data_in, bat_wr_valid_in, bat_wr_idx_in} = 5'h00;
        {tlb_ld_vpn_in, tlb_ld_ppn_in, tlb_inv_ea_in} = 92'h0;
        {bat_wr_eff_in, bat_wr_phys_in, bat_wr_mask_in} = 41'h0;
        supervisor_in = 1'b1;
        repeat (16) @(posedge mclk_in);
        @(negedge mclk_in) arst_n_in = 1'b1;
        t_reset();
        t_passthru();
        t_misses();
        t_pages();
        t_blocks();
        stop_test();
    end
endmodule // atu_bench

// [test/atu_core_model.sv]
// Core fetch and load/store request model
`timescale 1ns/1ps
module atu_core_model (
    // Clock
    input  wire        mclk_in,
    // Requests
    output reg         ifetch_req_out,
    output reg  [31:0] ifetch_ea_out,
    output reg         data_req_out,
    output reg         data_store_out,
    output reg  [31:0] data_ea_out
);
    // Idle at time zero
    initial begin
        ifetch_req_out = 1'b0;
        ifetch_ea_out = 32'h0;
        data_req_out = 1'b0;
        data_store_out = 1'b0;
        data_ea_out = 32'h0;
    end
    // One fetch or one load/store per call; released addresses are inverted so stale values
    // never look like a fresh request
    task issue(input logic dat, st, input logic [31:0] ea);
        @(negedge mclk_in);
        if (dat) begin
            data_req_out = 1'b1;
            data_store_out = st;
            data_ea_out = ea;
        end else begin
            ifetch_req_out = 1'b1;
            ifetch_ea_out = ea;
        end
        @(negedge mclk_in);
        ifetch_req_out = 1'b0;
        data_req_out = 1'b0;
        ifetch_ea_out = ~ifetch_ea_out;
        data_ea_out = ~data_ea_out;
    endtask
endmodule // atu_core_model

// [test/atu_top_asserts.sv]
// Port-level assertions for the address translation unit
`timescale 1ns/1ps
`include "atu_defs.vh"
module atu_top_asserts (
    // Clock, reset, enable
    input wire        mclk_in,
    input wire        arst_n_in,
    input wire        ce_in,
    // Requests
    input wire        instr_translate_enable_in,
    input wire        data_translate_enable_in,
    input wire        ifetch_req_in,
    input wire [31:0] ifetch_ea_in,
    input wire        data_req_in,
    input wire        data_store_in,
    input wire [31:0] data_ea_in,
    // Answers
    input wire        i_valid_out,
    input wire [31:0] i_pa_out,
    input wire        d_valid_out,
    input wire [31:0] d_pa_out,
    input wire        exc_out,
    input wire [19:0] exc_vector_out,
    input wire        prot_fault_out,
    input wire [31:0] miss_ea_out,
    input wire [31:0] grp_addr1_out,
    input wire [31:0] grp_addr2_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    // Requests taken with translation on
    wire i_on = ce_in && ifetch_req_in && instr_translate_enable_in;
    wire d_on = ce_in && data_req_in && data_translate_enable_in;
    wire i_ok = i_valid_out;
    wire d_ok = d_valid_out || prot_fault_out;

    a_ifetch_pass: assert property (ce_in && ifetch_req_in && !instr_translate_enable_in
        |=> i_valid_out && i_pa_out == $past(ifetch_ea_in)) else $error("fetch pass wrong");
    a_data_pass: assert property (ce_in && data_req_in && !data_translate_enable_in
        |=> d_valid_out && d_pa_out == $past(data_ea_in)) else $error("data pass wrong");
    a_off_no_miss: assert property (ce_in && !i_on && !d_on |=> !exc_out)
        else $error("miss while off");
    a_ivalid_cause: assert property (ce_in && !ifetch_req_in |=> !i_valid_out)
        else $error("fetch valid unasked");
    a_imiss_vec: assert property (i_on
        |=> i_ok || (exc_out && exc_vector_out == `ATU_VEC_IMISS)) else $error("fetch vector");
    a_load_vec: assert property (d_on && !data_store_in && !i_on
        |=> d_ok || (exc_out && exc_vector_out == `ATU_VEC_DLMISS)) else $error("load vector");
    a_store_vec: assert property (d_on && data_store_in && !i_on
        |=> d_ok || (exc_out && exc_vector_out == `ATU_VEC_DSMISS)) else $error("store vector");
    a_miss_ea_hold: assert property (!exc_out |-> $stable(miss_ea_out))
        else $error("miss address moved");
    a_miss_ea_value: assert property (exc_out && $past(ce_in) |-> miss_ea_out ==
        ($past(i_on) && !i_valid_out ? $past(ifetch_ea_in) : $past(data_ea_in)))
        else $error("miss address");
    a_group_align: assert property (exc_out
        |-> grp_addr1_out[5:0] == 6'h00 && grp_addr2_out[5:0] == 6'h00) else $error("group");
    a_page_offset: assert property ($past(ce_in) && d_valid_out
        |-> d_pa_out[11:0] == $past(data_ea_in[11:0])) else $error("page offset");
endmodule // atu_top_asserts

bind atu_top atu_top_asserts atu_top_asserts_inst (.mclk_in, .arst_n_in, .ce_in,
    .instr_translate_enable_in, .data_translate_enable_in, .ifetch_req_in, .ifetch_ea_in,
    .data_req_in, .data_store_in, .data_ea_in, .i_valid_out, .i_pa_out, .d_valid_out,
    .d_pa_out, .exc_out, .exc_vector_out, .prot_fault_out, .miss_ea_out, .grp_addr1_out,
    .grp_addr2_out);

// [verilog/atu_bat.v]
// Four-entry block translation array with software load
`timescale 1ns/1ps
`include "atu_defs.vh"
module atu_bat #(
    parameter N = `ATU_BAT_ENTRIES
) (
    // Clock and reset
    input  wire        mclk_in,
    input  wire        arst_n_in,
    input  wire        ce_in,
    // Software load port
    input  wire        wr_in,
    input  wire [1:0]  wr_idx_in,
    input  wire        wr_valid_in,
    input  wire [14:0] wr_eff_in,
    input  wire [14:0] wr_phys_in,
    input  wire [10:0] wr_mask_in,
    input  wire        wr_wp_in,
    // Lookup
    input  wire [31:0] ea_in,
    output reg         hit_out,
    output reg         wprot_out,
    output reg  [31:0] pa_out
);
    reg        v_r  [0:N-1];
    reg [14:0] be_r [0:N-1];
    reg [14:0] bp_r [0:N-1];
    reg [10:0] bm_r [0:N-1];
    reg        wp_r [0:N-1];
    integer    i;
    reg [14:0] m;

    // Entries loaded by system software; block 128 KB (mask 0) to 256 MB (mask all ones)
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : ent
            always @(posedge mclk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    v_r[g]  <= 1'b0;
                    be_r[g] <= 15'h0000;
                    bp_r[g] <= 15'h0000;
                    bm_r[g] <= 11'h000;
                    wp_r[g] <= 1'b0;
                end else if (ce_in && wr_in && wr_idx_in == g) begin // R14
                    v_r[g]  <= wr_valid_in;
                    be_r[g] <= wr_eff_in;
                    bp_r[g] <= wr_phys_in;
                    bm_r[g] <= wr_mask_in; // R8
                    wp_r[g] <= wr_wp_in;
                end
            end
        end
    endgenerate

    // Parallel compare; the lowest index wins on overlap
    always @* begin
        hit_out   = 1'b0;
        wprot_out = 1'b0;
        pa_out    = ea_in;
        m         = 15'h0000;
        for (i = N - 1; i >= 0; i = i - 1) begin
            m = {4'h0, bm_r[i]};
            if (v_r[i] && ((ea_in[31:17] & ~m) == (be_r[i] & ~m))) begin // R1
                hit_out   = 1'b1;
                wprot_out = wp_r[i];
                pa_out    = {(bp_r[i] & ~m) | (ea_in[31:17] & m), ea_in[16:0]};
            end
        end
    end
endmodule // atu_bat

// [verilog/atu_tlb.v]
// Two-way set-associative page translation buffer
`timescale 1ns/1ps
`include "atu_defs.vh"
module atu_tlb #(
    parameter SETS = `ATU_TLB_SETS,
    parameter SB   = `ATU_TLB_SET_BITS
) (
    // Clock and reset
    input  wire        mclk_in,
    input  wire        arst_n_in,
    input  wire        ce_in,
    // Software reload
    input  wire        ld_in,
    input  wire [39:0] ld_vpn_in,
    input  wire [19:0] ld_ppn_in,
    input  wire        ld_chg_in,
    input  wire [1:0]  ld_pp_in,
    // Selective invalidate by effective page
    input  wire        inv_in,
    input  wire [SB-1:0] inv_set_in,
    // Lookup with the 40-bit virtual page number
    input  wire [39:0] vpn_in,
    output reg         hit_out,
    output reg         chg_out,
    output reg  [1:0]  pp_out,
    output reg  [19:0] ppn_out
);
    reg        v_r   [0:2*SETS-1];
    reg [39:0] tag_r [0:2*SETS-1];
    reg [19:0] ppn_r [0:2*SETS-1];
    reg        c_r   [0:2*SETS-1];
    reg [1:0]  pp_r  [0:2*SETS-1];
    reg        lru_r [0:SETS-1];
    wire [SB-1:0] set    = vpn_in[SB-1:0];
    wire [SB-1:0] ld_set = ld_vpn_in[SB-1:0];
    wire [SB:0]   w0     = {set, 1'b0};
    wire [SB:0]   w1     = {set, 1'b1};
    wire          h0     = v_r[w0] && tag_r[w0] == vpn_in;
    wire          h1     = v_r[w1] && tag_r[w1] == vpn_in;
    wire [SB:0]   lw     = {ld_set, lru_r[ld_set]};
    integer       k;

    // Combinational lookup so a hit costs no extra cycle beside the cache
    always @* begin
        hit_out = h0 | h1; // R9
        chg_out = h1 ? c_r[w1] : c_r[w0];
        pp_out  = h1 ? pp_r[w1] : pp_r[w0];
        ppn_out = h1 ? ppn_r[w1] : ppn_r[w0];
    end

    // Reload replaces the least recent way; invalidate clears both ways of a set
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (k = 0; k < 2 * SETS; k = k + 1) begin
                v_r[k]   <= 1'b0;
                tag_r[k] <= 40'h0;
                ppn_r[k] <= 20'h0;
                c_r[k]   <= 1'b0;
                pp_r[k]  <= 2'h0;
            end
            for (k = 0; k < SETS; k = k + 1)
                lru_r[k] <= 1'b0;
        end else if (ce_in) begin
            if (ld_in) begin // R10
                v_r[lw]   <= 1'b1;
                tag_r[lw] <= ld_vpn_in;
                ppn_r[lw] <= ld_ppn_in;
                c_r[lw]   <= ld_chg_in;
                pp_r[lw]  <= ld_pp_in;
                lru_r[ld_set] <= ~lru_r[ld_set];
            end else if (inv_in) begin // R12
                v_r[{inv_set_in, 1'b0}] <= 1'b0;
                v_r[{inv_set_in, 1'b1}] <= 1'b0;
            end else if (h0 | h1) begin
                lru_r[set] <= h0;
            end
        end
    end
endmodule // atu_tlb

// [verilog/atu_top.v]
// Address translation unit: page buffers, block arrays and miss reporting
`timescale 1ns/1ps
`include "atu_defs.vh"
// Contract
// R1: Map every effective address to physical, protecting blocks and pages.
// R2: Translate instruction fetches and load/store data accesses.
// R3: Translate only while the matching translation enable bit is set.
// R4: Software sizes page table as power of two, aligned to size.
// R5: Entry groups hold eight 8-byte entries, 64 bytes, search entry points.
// R6: 4 GB logical space, 4 KB pages, 256 MB segments.
// R7: Form 52-bit virtual address, produce 32-bit physical address.
// R8: Block sizes from 128 KB to 256 MB, chosen by software.
// R9: Buffer lookup parallel with cache; a hit adds no cycles.
// R10: Separate instruction and data buffers, 64 entries, two-way.
// R11: Give hardware assist to the software table search on a miss.
// R12: Supervisor software may invalidate entries selectively.
// R13: Software keeps buffers consistent with the page table.
// R14: Independent four-entry block arrays for instruction and data, software loaded.
// R15: Instruction miss raises exception at vector 01000.
// R16: Load miss raises exception at vector 01100.
// R17: Store miss or change bit unset raises exception at vector 01200.
// R18: Paging and protection rely on exceptions, not hardware reload.
// R19: With translation off, pass address through and raise no miss.
module atu_top (
    // Clock, reset, enable
    input  wire        mclk_in,
    input  wire        arst_n_in,
    input  wire        ce_in,
    // Machine state word bits
    input  wire        instr_translate_enable_in,
    input  wire        data_translate_enable_in,
    input  wire        supervisor_in,
    // Segment register file view (VSID for each 256 MB segment)
    input  wire [23:0] i_vsid_in,
    input  wire [23:0] d_vsid_in,
    // Page table base and mask for search assist
    input  wire [15:0] table_base_in,
    input  wire [8:0]  table_mask_in,
    // Instruction fetch request
    input  wire        ifetch_req_in,
    input  wire [31:0] ifetch_ea_in,
    // Data request
    input  wire        data_req_in,
    input  wire        data_store_in,
    input  wire [31:0] data_ea_in,
    // Buffer reload and invalidate (supervisor software)
    input  wire        tlb_ld_in,
    input  wire        tlb_ld_data_in,
    input  wire [39:0] tlb_ld_vpn_in,
    input  wire [19:0] tlb_ld_ppn_in,
    input  wire        tlb_ld_chg_in,
    input  wire [1:0]  tlb_ld_pp_in,
    input  wire        tlb_inv_in,
    input  wire [31:0] tlb_inv_ea_in,
    // Block array load
    input  wire        bat_wr_in,
    input  wire        bat_wr_data_in,
    input  wire [1:0]  bat_wr_idx_in,
    input  wire        bat_wr_valid_in,
    input  wire [14:0] bat_wr_eff_in,
    input  wire [14:0] bat_wr_phys_in,
    input  wire [10:0] bat_wr_mask_in,
    input  wire        bat_wr_wp_in,
    // Instruction answer
    output reg         i_valid_out,
    output reg  [31:0] i_pa_out,
    // Data answer
    output reg         d_valid_out,
    output reg  [31:0] d_pa_out,
    // Exceptions
    output reg         exc_out,
    output reg  [19:0] exc_vector_out,
    output reg         prot_fault_out,
    // Search assist
    output reg  [31:0] miss_ea_out,
    output reg  [31:0] grp_addr1_out,
    output reg  [31:0] grp_addr2_out
);
    // Lookup results from the block arrays and page buffers
    wire        ib_hit;
    wire        ib_wp;
    wire [31:0] ib_pa;
    wire        db_hit;
    wire        db_wp;
    wire [31:0] db_pa;
    wire        it_hit;
    wire        it_chg;
    wire [1:0]  it_pp;
    wire [19:0] it_ppn;
    wire        dt_hit;
    wire        dt_chg;
    wire [1:0]  dt_pp;
    wire [19:0] dt_ppn;

    // Virtual page number: VSID joined with the page index of the segment;
    // the segment number only picks the VSID, which arrives from outside
    wire [39:0] i_vpn = {i_vsid_in, ifetch_ea_in[27:12]}; // R7
    wire [39:0] d_vpn = {d_vsid_in, data_ea_in[27:12]}; // R7
    wire [4:0]  inv_set = tlb_inv_ea_in[16:12];

    // Load strobes steered to one side, invalidate to both; page buffer changes need supervisor state
    wire        i_ld  = tlb_ld_in & ~tlb_ld_data_in & supervisor_in;
    wire        d_ld  = tlb_ld_in & tlb_ld_data_in & supervisor_in;
    wire        t_inv = tlb_inv_in & supervisor_in; // R12
    wire        ib_wr = bat_wr_in & ~bat_wr_data_in;
    wire        db_wr = bat_wr_in & bat_wr_data_in;

    // Group addresses for the table search: primary hash and its complement.
    // The mask widens the index into the base; a table that is not aligned to
    // its own size would lose the base bits that the mask covers.
    function [31:0] grp_addr;
        input [23:0] vsid;
        input [15:0] pidx;
        input        sec;
        reg   [18:0] h;
        begin
            h = vsid[18:0] ^ {3'h0, pidx};
            if (sec)
                h = ~h;
            grp_addr = {table_base_in[15:9],
                        (table_base_in[8:0] & ~table_mask_in) | (h[18:10] & table_mask_in),
                        h[9:0], 6'h00}; // R5
        end
    endfunction

    // Page protection: key 0 for supervisor, user write needs read-write encoding
    // Supervisor writes anything but read-only; user writes need read-write
    function wr_ok;
        input [1:0] pp;
        input       sup;
        begin
            wr_ok = sup ? (pp != `ATU_PP_RO) : (pp == `ATU_PP_RW);
        end
    endfunction

    // One block array per side, both loaded through the shared write port
    atu_bat u_ibat (
        .mclk_in    (mclk_in),
        .arst_n_in  (arst_n_in),
        .ce_in      (ce_in),
        .wr_in      (ib_wr),
        .wr_idx_in  (bat_wr_idx_in),
        .wr_valid_in(bat_wr_valid_in),
        .wr_eff_in  (bat_wr_eff_in),
        .wr_phys_in (bat_wr_phys_in),
        .wr_mask_in (bat_wr_mask_in),
        .wr_wp_in   (bat_wr_wp_in),
        .ea_in      (ifetch_ea_in),
        .hit_out    (ib_hit),
        .wprot_out  (ib_wp),
        .pa_out     (ib_pa)
    );

    atu_bat u_dbat (
        .mclk_in    (mclk_in),
        .arst_n_in  (arst_n_in),
        .ce_in      (ce_in),
        .wr_in      (db_wr),
        .wr_idx_in  (bat_wr_idx_in),
        .wr_valid_in(bat_wr_valid_in),
        .wr_eff_in  (bat_wr_eff_in),
        .wr_phys_in (bat_wr_phys_in),
        .wr_mask_in (bat_wr_mask_in),
        .wr_wp_in   (bat_wr_wp_in),
        .ea_in      (data_ea_in),
        .hit_out    (db_hit),
        .wprot_out  (db_wp),
        .pa_out     (db_pa)
    );

    // One page buffer per side, sharing the reload and invalidate port
    atu_tlb u_ibuf (
        .mclk_in   (mclk_in),
        .arst_n_in (arst_n_in),
        .ce_in     (ce_in),
        .ld_in     (i_ld),
        .ld_vpn_in (tlb_ld_vpn_in),
        .ld_ppn_in (tlb_ld_ppn_in),
        .ld_chg_in (tlb_ld_chg_in),
        .ld_pp_in  (tlb_ld_pp_in),
        .inv_in    (t_inv),
        .inv_set_in(inv_set),
        .vpn_in    (i_vpn),
        .hit_out   (it_hit),
        .chg_out   (it_chg),
        .pp_out    (it_pp),
        .ppn_out   (it_ppn)
    );

    atu_tlb u_dbuf (
        .mclk_in   (mclk_in),
        .arst_n_in (arst_n_in),
        .ce_in     (ce_in),
        .ld_in     (d_ld),
        .ld_vpn_in (tlb_ld_vpn_in),
        .ld_ppn_in (tlb_ld_ppn_in),
        .ld_chg_in (tlb_ld_chg_in),
        .ld_pp_in  (tlb_ld_pp_in),
        .inv_in    (t_inv),
        .inv_set_in(inv_set),
        .vpn_in    (d_vpn),
        .hit_out   (dt_hit),
        .chg_out   (dt_chg),
        .pp_out    (dt_pp),
        .ppn_out   (dt_ppn)
    );

    // Next-state decisions; block arrays take priority over page buffers
    reg        i_ok;
    reg        i_miss;
    reg [31:0] i_pa;
    reg        d_ok;
    reg        d_miss;
    reg        d_prot;
    reg [31:0] d_pa;
    always @* begin
        i_ok   = 1'b0;
        i_miss = 1'b0;
        i_pa   = ifetch_ea_in;
        if (!instr_translate_enable_in) begin // R3
            i_ok = ifetch_req_in; // R19
        end else if (ib_hit) begin // R14
            i_ok = ifetch_req_in;
            i_pa = ib_pa;
        end else if (it_hit) begin // R2
            i_ok = ifetch_req_in;
            i_pa = {it_ppn, ifetch_ea_in[11:0]}; // R6
        end else begin
            i_miss = ifetch_req_in; // R15
        end
    end

    // Data side: a store also checks write permission and the change bit
    always @* begin
        d_ok   = 1'b0;
        d_miss = 1'b0;
        d_prot = 1'b0;
        d_pa   = data_ea_in;
        if (!data_translate_enable_in) begin // R3
            d_ok = data_req_in; // R19
        end else if (db_hit) begin
            d_pa = db_pa;
            if (data_store_in && db_wp)
                d_prot = data_req_in; // R1
            else
                d_ok = data_req_in;
        end else if (dt_hit) begin
            d_pa = {dt_ppn, data_ea_in[11:0]};
            if (data_store_in && !wr_ok(dt_pp, supervisor_in))
                d_prot = data_req_in; // R1
            else if (data_store_in && !dt_chg)
                d_miss = data_req_in; // R17
            else
                d_ok = data_req_in;
        end else begin
            d_miss = data_req_in; // R16
        end
    end

    // Registered answers; the address follows every cycle, valid only a taken request
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            i_valid_out    <= 1'b0;
            i_pa_out       <= 32'h00000000;
            d_valid_out    <= 1'b0;
            d_pa_out       <= 32'h00000000;
        end else if (ce_in) begin
            i_valid_out    <= i_ok;
            i_pa_out       <= i_pa;
            d_valid_out    <= d_ok;
            d_pa_out       <= d_pa;
        end
    end

    // Exception report; instruction miss wins a tie and the core retries the data access.
    // Vector, missed address and group addresses hold until the next miss so the
    // handler may read them late; the strobes last one cycle only.
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            exc_out        <= 1'b0;
            exc_vector_out <= 20'h00000;
            prot_fault_out <= 1'b0;
            miss_ea_out    <= 32'h00000000;
            grp_addr1_out  <= 32'h00000000;
            grp_addr2_out  <= 32'h00000000;
        end else if (ce_in) begin
            exc_out        <= i_miss | d_miss; // R18
            prot_fault_out <= d_prot;
            if (i_miss) begin
                exc_vector_out <= `ATU_VEC_IMISS; // R15
                miss_ea_out    <= ifetch_ea_in;
                grp_addr1_out  <= grp_addr(i_vsid_in, ifetch_ea_in[27:12], 1'b0); // R11
                grp_addr2_out  <= grp_addr(i_vsid_in, ifetch_ea_in[27:12], 1'b1); // R11
            end else if (d_miss) begin
                exc_vector_out <= data_store_in ? `ATU_VEC_DSMISS : `ATU_VEC_DLMISS; // R16
                miss_ea_out    <= data_ea_in;
                grp_addr1_out  <= grp_addr(d_vsid_in, data_ea_in[27:12], 1'b0); // R11
                grp_addr2_out  <= grp_addr(d_vsid_in, data_ea_in[27:12], 1'b1); // R11
            end
        end
    end
endmodule // atu_top
